// file: core/owd_bus_slave.sv
// option word decoder: avalon-mm status and control slave
`timescale 1ns/100ps
`default_nettype none
module owd_bus_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  owd_cfg_if.slave cfg
);
  import owd_pkg::*;

  owd_bus_e state_reg;
  owd_bus_e state_next;
  logic fault_reg;
  logic fault_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic req;
  logic commit;
  logic clr_hit;
  logic wait_reg;
  logic wait_next;

  assign req = avs_read || avs_write;
  // the pin comes from its own flop, not from a compare on the state
  assign wait_next = state_next != OWD_BUS_ACK;
  assign commit = (state_reg == OWD_BUS_ACK) && req;
  assign state_next = (state_reg == OWD_BUS_IDLE && req) ?
    OWD_BUS_ACK : OWD_BUS_IDLE;
  assign clr_hit = commit && avs_write && avs_address == OWD_ADDR_CTRL &&
    avs_writedata[OWD_CTRL_FAULT_CLR];
  // a fault arriving with the clear still lands
  assign fault_next = cfg.fault_set || (fault_reg && !clr_hit);

  // option words never reach this port; only load and fault status do
  always_comb begin
    rdata_next = '0;
    if (avs_address == OWD_ADDR_STATUS) begin
      rdata_next[OWD_STS_LOADED] = cfg.valid;
      rdata_next[OWD_STS_FAULT] = fault_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= OWD_BUS_IDLE;
      fault_reg <= 1'b0;
      rdata_reg <= '0;
      wait_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      fault_reg <= fault_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

  bus_ack_single_a: assert property (@(posedge clk) disable iff (!rst_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  bus_ack_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && avs_waitrequest && state_reg == OWD_BUS_IDLE) |=>
    !avs_waitrequest)
    else $error("request not answered on the next edge");
  read_hides_words_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    !avs_waitrequest |-> avs_readdata[31:OWD_STS_FAULT+1] == '0)
    else $error("read data exposes more than status");
endmodule
`default_nettype wire

// file: core/owd_capture.sv
// option word decoder: one-shot capture of the option words
`timescale 1ns/100ps
`default_nettype none
module owd_capture (
  input wire logic clk,
  input wire logic rst_n,
  input wire owd_pkg::owd_word_t otp_word0,
  input wire owd_pkg::owd_word_t otp_word1,
  input wire owd_pkg::owd_word_t otp_word2,
  owd_cfg_if.capture cfg
);
  import owd_pkg::*;

  owd_word_t w0_reg;
  owd_word_t w1_reg;
  owd_word_t w2_reg;
  logic valid_reg;
  logic load_reg;
  logic valid_next;

  // words are taken on the first edge after reset release, then frozen
  assign valid_next = 1'b1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w0_reg <= '0;
      w1_reg <= '0;
      w2_reg <= '0;
      valid_reg <= 1'b0;
      load_reg <= 1'b0;
    end else begin
      load_reg <= !valid_reg;
      if (!valid_reg) begin
        w0_reg <= otp_word0;
        w1_reg <= otp_word1;
        w2_reg <= otp_word2;
        valid_reg <= valid_next;
      end
    end
  end

  assign cfg.word0 = w0_reg;
  assign cfg.word1 = w1_reg;
  assign cfg.word2 = w2_reg;
  assign cfg.valid = valid_reg;
  assign cfg.load_pulse = load_reg;
endmodule
`default_nettype wire

// file: core/owd_top.sv
// option word decoder: top level, decode of three option words
//
// Contract
// - option words sit outside program memory; software can never read them.
// - first word bit 12 at 0 makes the shared pin an active-low reset.
// - first word bit 11 at 0 turns the watchdog on, 1 off.
// - first word bit 10 picks two or four oscillator periods per cycle.
// - low-supply reset bits: 11 none, 10 2.7/2.9V, 01 3.5/3.7V, 00 4.0V.
// - watchdog period bits: 11 18ms, 10 4.5ms, 01 288ms, 00 72ms.
// - falling-edge interrupt; width bit 0 gives 8/fc, 1 gives 32/fc.
// - glitch filter follows its bit, but stays off in watch crystal mode.
// - each of three protect bits at 0 protects program memory.
// - second word bit 12 at 0 selects low power, 1 high power.
// - rc frequency bits: 11 4MHz, 10 16MHz, 01 8MHz, 00 1MHz.
// - four source bits pick rc or crystal mode; odd rc codes give clock out.
// - on-chip rc frees the rc pin as port; outside rc uses it as oscillator.
// - every crystal mode dedicates both crystal pins to the oscillator.
// - in rc modes clock-out bit 1 drives system clock, 0 open drain.
// - third word bit 11 picks 128kHz at 0, 16kHz at 1 sub-clock.
// - third word bit 10 marks 10-pin at 0, 14-pin at 1.
// - third word low ten bits carry customer id, no effect elsewhere.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module owd_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire owd_pkg::owd_word_t otp_word0,
  input wire owd_pkg::owd_word_t otp_word1,
  input wire owd_pkg::owd_word_t otp_word2,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic cfg_valid,
  output logic ext_reset_pin_en,
  output logic watchdog_en,
  output logic instr_four_clocks,
  output logic lvr_enabled,
  output logic [5:0] lvr_trip_dv,
  output logic [5:0] lvr_release_dv,
  output logic [18:0] wdt_timeout_us,
  output logic int_falling_edge,
  output logic [5:0] int_glitch_width_fc,
  output logic int_filter_en,
  output logic [2:0] code_protect,
  output logic low_power_mode,
  output logic [4:0] irc_freq_mhz,
  output logic [3:0] clock_source_select,
  output logic outside_rc_osc_mode,
  output logic on_chip_rc_osc_mode,
  output logic crystal_pins_dedicated,
  output logic rc_input_is_osc,
  output logic shared_rc_pin_is_io,
  output logic clk_out_pin_en,
  output logic clk_out_sysclk,
  output logic clk_out_open_drain,
  output logic green_sub_128k,
  output logic pkg_14pin,
  output logic [9:0] customer_ident_field
);
  import owd_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_int_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_int_n = rst_sync_reg;

  // ---------------------------------------------------------------
  // capture and bus
  // ---------------------------------------------------------------
  owd_cfg_if cfg ();

  owd_capture u_capture (
    .clk(clk),
    .rst_n(rst_int_n),
    .otp_word0(otp_word0),
    .otp_word1(otp_word1),
    .otp_word2(otp_word2),
    .cfg(cfg.capture)
  );

  // the slave has no path to the words, so the program cannot see them
  owd_bus_slave u_bus (
    .clk(clk),
    .rst_n(rst_int_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cfg(cfg.slave)
  );

  // ---------------------------------------------------------------
  // field decode functions
  // ---------------------------------------------------------------
  function automatic logic [5:0] lvr_trip(input logic [1:0] sel);
    unique case (sel)
      OWD_LVR_POR: lvr_trip = OWD_DV_NONE;
      OWD_LVR_27: lvr_trip = OWD_DV_27;
      OWD_LVR_35: lvr_trip = OWD_DV_35;
      default: lvr_trip = OWD_DV_40;
    endcase
  endfunction

  // release level for the 4.0V setting equals its trip level
  function automatic logic [5:0] lvr_release(input logic [1:0] sel);
    unique case (sel)
      OWD_LVR_POR: lvr_release = OWD_DV_NONE;
      OWD_LVR_27: lvr_release = OWD_DV_29;
      OWD_LVR_35: lvr_release = OWD_DV_37;
      default: lvr_release = OWD_DV_40;
    endcase
  endfunction

  function automatic logic [18:0] wdt_period(input logic [1:0] sel);
    unique case (sel)
      OWD_WDT_SEL_18: wdt_period = OWD_WDT_18MS_US;
      OWD_WDT_SEL_4P5: wdt_period = OWD_WDT_4P5MS_US;
      OWD_WDT_SEL_288: wdt_period = OWD_WDT_288MS_US;
      default: wdt_period = OWD_WDT_72MS_US;
    endcase
  endfunction

  function automatic logic [4:0] irc_freq(input logic [1:0] sel);
    unique case (sel)
      OWD_IRC_SEL_4: irc_freq = OWD_IRC_4MHZ;
      OWD_IRC_SEL_16: irc_freq = OWD_IRC_16MHZ;
      OWD_IRC_SEL_8: irc_freq = OWD_IRC_8MHZ;
      default: irc_freq = OWD_IRC_1MHZ;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  owd_word_t w0;
  owd_word_t w1;
  owd_word_t w2;
  logic [1:0] lvr_sel;
  logic [1:0] wdt_sel;
  logic [1:0] rcm_sel;
  logic [3:0] osc_code;
  logic [4:0] trim_bits;
  logic is_outside_rc;
  logic is_on_chip_rc;
  logic is_rc;
  logic is_watch_xtal;
  logic is_known_xtal;
  logic osc_unknown;
  logic layout_fault;

  assign w0 = cfg.word0;
  assign w1 = cfg.word1;
  assign w2 = cfg.word2;
  assign lvr_sel = w0[W0_LVR_HI:W0_LVR_LO];
  assign wdt_sel = w0[W0_WDT_HI:W0_WDT_LO];
  assign rcm_sel = w1[W1_RCM_HI:W1_RCM_LO];
  assign osc_code = w1[W1_OSC_HI:W1_OSC_LO];
  assign trim_bits = w1[W1_TRIM_HI:W1_TRIM_LO];

  assign is_outside_rc = osc_code == OWD_OUTSIDE_RC_PORT ||
    osc_code == OWD_OUTSIDE_RC_CLKOUT;
  assign is_on_chip_rc = osc_code == OWD_ON_CHIP_RC_PORT ||
    osc_code == OWD_ON_CHIP_RC_CLKOUT;
  assign is_rc = is_outside_rc || is_on_chip_rc;
  assign is_watch_xtal = osc_code == OWD_WATCH_XTAL;
  assign is_known_xtal = osc_code == OWD_LOW_XTAL_ONE ||
    osc_code == OWD_HIGH_XTAL_ONE || is_watch_xtal ||
    osc_code == OWD_HIGH_XTAL_TWO || osc_code == OWD_MID_XTAL;
  // undefined source codes keep the crystal pins out of port use
  assign osc_unknown = !is_rc && !is_known_xtal;

  // words the programmer left off-pattern are reported, not corrected
  assign layout_fault = !w0[W0_KEEP1] || !w2[W2_KEEP1] ||
    trim_bits != OWD_TRIM_ALL || osc_unknown;
  assign cfg.fault_set = cfg.load_pulse && layout_fault;

  // ---------------------------------------------------------------
  // held outputs, loaded once per reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cfg_valid <= 1'b0;
      ext_reset_pin_en <= 1'b0;
      watchdog_en <= 1'b0;
      instr_four_clocks <= 1'b0;
      lvr_enabled <= 1'b0;
      lvr_trip_dv <= '0;
      lvr_release_dv <= '0;
      wdt_timeout_us <= '0;
      int_falling_edge <= 1'b0;
      int_glitch_width_fc <= '0;
      int_filter_en <= 1'b0;
      code_protect <= '0;
      low_power_mode <= 1'b0;
      irc_freq_mhz <= '0;
      clock_source_select <= '0;
      outside_rc_osc_mode <= 1'b0;
      on_chip_rc_osc_mode <= 1'b0;
      crystal_pins_dedicated <= 1'b0;
      rc_input_is_osc <= 1'b0;
      shared_rc_pin_is_io <= 1'b0;
      clk_out_pin_en <= 1'b0;
      clk_out_sysclk <= 1'b0;
      clk_out_open_drain <= 1'b0;
      green_sub_128k <= 1'b0;
      pkg_14pin <= 1'b0;
      customer_ident_field <= '0;
    end else if (cfg.load_pulse) begin
      cfg_valid <= 1'b1;
      ext_reset_pin_en <= !w0[W0_RST_PIN];
      watchdog_en <= !w0[W0_WDT_OFF];
      instr_four_clocks <= w0[W0_INSTR];
      lvr_enabled <= lvr_sel != OWD_LVR_POR;
      lvr_trip_dv <= lvr_trip(lvr_sel);
      lvr_release_dv <= lvr_release(lvr_sel);
      wdt_timeout_us <= wdt_period(wdt_sel);
      int_falling_edge <= 1'b1;
      int_glitch_width_fc <= w0[W0_NR_WIDTH] ?
        OWD_GLITCH_LONG_FC : OWD_GLITCH_SHORT_FC;
      int_filter_en <= w0[W0_NR_EN] && !is_watch_xtal;
      code_protect <= ~w0[W0_PROT_HI:W0_PROT_LO];
      low_power_mode <= !w1[W1_POWER];
      irc_freq_mhz <= irc_freq(rcm_sel);
      clock_source_select <= osc_code;
      outside_rc_osc_mode <= is_outside_rc;
      on_chip_rc_osc_mode <= is_on_chip_rc;
      crystal_pins_dedicated <= !is_rc;
      rc_input_is_osc <= is_outside_rc;
      shared_rc_pin_is_io <= is_on_chip_rc;
      clk_out_pin_en <= is_rc && osc_code[OSC_CLKOUT_BIT];
      clk_out_sysclk <= is_rc && osc_code[OSC_CLKOUT_BIT] &&
        w1[W1_CLKOUT];
      clk_out_open_drain <= is_rc && osc_code[OSC_CLKOUT_BIT] &&
        !w1[W1_CLKOUT];
      green_sub_128k <= !w2[W2_SUBCLK];
      pkg_14pin <= w2[W2_PKG];
      customer_ident_field <= w2[W2_ID_HI:W2_ID_LO];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  load_once_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid |-> !cfg.load_pulse && $stable(w0) && $stable(w1) &&
    $stable(w2))
    else $error("option words changed after load");

  outputs_hold_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid ##1 cfg_valid |-> $stable(watchdog_en) &&
    $stable(clock_source_select) && $stable(customer_ident_field))
    else $error("decoded output moved while held");

  load_timing_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    $rose(cfg.valid) |=> cfg_valid ##0 $past(cfg_valid) == 1'b0)
    else $error("outputs not valid one edge after capture");

  reset_pin_a: assert property (@(posedge clk) disable iff (!rst_int_n)
    cfg_valid |-> ext_reset_pin_en == !w0[W0_RST_PIN])
    else $error("reset pin select does not follow its bit");

  watchdog_on_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid |-> watchdog_en != w0[W0_WDT_OFF])
    else $error("watchdog enable inverted");

  lvr_levels_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid && lvr_sel == OWD_LVR_27 |->
    lvr_trip_dv == OWD_DV_27 && lvr_release_dv == OWD_DV_29 &&
    lvr_enabled)
    else $error("2.7V reset level wrong");

  wdt_period_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid && wdt_sel == OWD_WDT_SEL_288 |->
    wdt_timeout_us == OWD_WDT_288MS_US)
    else $error("watchdog period decode wrong");

  filter_watch_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid && clock_source_select == OWD_WATCH_XTAL |-> !int_filter_en)
    else $error("filter on in watch crystal mode");

  glitch_width_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid |-> int_glitch_width_fc == (w0[W0_NR_WIDTH] ?
    OWD_GLITCH_LONG_FC : OWD_GLITCH_SHORT_FC) && int_falling_edge)
    else $error("interrupt glitch width wrong");

  xtal_pins_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid && crystal_pins_dedicated |->
    !shared_rc_pin_is_io && !clk_out_pin_en && !rc_input_is_osc)
    else $error("crystal pin released in crystal mode");

  clk_out_mode_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid |-> !(clk_out_sysclk && clk_out_open_drain) &&
    ((clk_out_sysclk || clk_out_open_drain) == clk_out_pin_en))
    else $error("clock-out pin mode inconsistent");

  fault_flag_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg.load_pulse && !w0[W0_KEEP1] |-> cfg.fault_set)
    else $error("keep-one bit violation not flagged");

  instr_period_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid |-> instr_four_clocks == w0[W0_INSTR])
    else $error("instruction period select wrong");

  protect_power_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid |-> code_protect == ~w0[W0_PROT_HI:W0_PROT_LO] &&
    low_power_mode != w1[W1_POWER])
    else $error("protect or power mode wrong");

  irc_freq_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid && rcm_sel == OWD_IRC_SEL_16 |-> irc_freq_mhz == OWD_IRC_16MHZ)
    else $error("rc frequency decode wrong");

  rc_pin_use_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid && on_chip_rc_osc_mode |-> shared_rc_pin_is_io && !rc_input_is_osc)
    else $error("rc pin not released in on-chip rc mode");

  ident_held_a: assert property (@(posedge clk)
    disable iff (!rst_int_n)
    cfg_valid |-> green_sub_128k != w2[W2_SUBCLK] && pkg_14pin == w2[W2_PKG] &&
    customer_ident_field == w2[W2_ID_HI:W2_ID_LO])
    else $error("third word fields not carried");
endmodule
`default_nettype wire

// file: include/owd_cfg_if.sv
// option word decoder: captured words and status between modules
`timescale 1ns/100ps
`default_nettype none
interface owd_cfg_if;
  import owd_pkg::*;
  owd_word_t word0;
  owd_word_t word1;
  owd_word_t word2;
  logic valid;
  logic load_pulse;
  logic fault_set;
  modport capture (output word0, output word1, output word2,
    output valid, output load_pulse);
  modport core (input word0, input word1, input word2,
    input valid, input load_pulse, output fault_set);
  modport slave (input valid, input fault_set);
endinterface
`default_nettype wire

// file: include/owd_pkg.sv
// option word decoder: shared constants, codes and types
package owd_pkg;

  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int OWD_W = 13;
  typedef logic [OWD_W-1:0] owd_word_t;

  localparam int W0_RST_PIN = 12;
  localparam int W0_WDT_OFF = 11;
  localparam int W0_INSTR = 10;
  localparam int W0_LVR_HI = 9;
  localparam int W0_LVR_LO = 8;
  localparam int W0_KEEP1 = 7;
  localparam int W0_WDT_HI = 6;
  localparam int W0_WDT_LO = 5;
  localparam int W0_NR_WIDTH = 4;
  localparam int W0_NR_EN = 3;
  localparam int W0_PROT_HI = 2;
  localparam int W0_PROT_LO = 0;

  localparam int W1_POWER = 12;
  localparam int W1_TRIM_HI = 11;
  localparam int W1_TRIM_LO = 7;
  localparam int W1_RCM_HI = 6;
  localparam int W1_RCM_LO = 5;
  localparam int W1_OSC_HI = 4;
  localparam int W1_OSC_LO = 1;
  localparam int W1_CLKOUT = 0;

  localparam int W2_KEEP1 = 12;
  localparam int W2_SUBCLK = 11;
  localparam int W2_PKG = 10;
  localparam int W2_ID_HI = 9;
  localparam int W2_ID_LO = 0;

  localparam int OSC_CLKOUT_BIT = 0;
  localparam logic [4:0] OWD_TRIM_ALL = 5'h1f;

  // ---------------------------------------------------------------
  // field codes and decoded values
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OWD_OUTSIDE_RC_PORT = 4'h0,
    OWD_OUTSIDE_RC_CLKOUT = 4'h1,
    OWD_ON_CHIP_RC_PORT = 4'h2,
    OWD_ON_CHIP_RC_CLKOUT = 4'h3,
    OWD_LOW_XTAL_ONE = 4'h4,
    OWD_HIGH_XTAL_ONE = 4'h5,
    OWD_WATCH_XTAL = 4'h6,
    OWD_HIGH_XTAL_TWO = 4'h7,
    OWD_MID_XTAL = 4'hf
  } owd_osc_e;

  localparam logic [1:0] OWD_LVR_POR = 2'h3;
  localparam logic [1:0] OWD_LVR_27 = 2'h2;
  localparam logic [1:0] OWD_LVR_35 = 2'h1;
  localparam logic [5:0] OWD_DV_NONE = 6'h00;
  localparam logic [5:0] OWD_DV_27 = 6'h1b;
  localparam logic [5:0] OWD_DV_29 = 6'h1d;
  localparam logic [5:0] OWD_DV_35 = 6'h23;
  localparam logic [5:0] OWD_DV_37 = 6'h25;
  localparam logic [5:0] OWD_DV_40 = 6'h28;

  localparam logic [1:0] OWD_WDT_SEL_18 = 2'h3;
  localparam logic [1:0] OWD_WDT_SEL_4P5 = 2'h2;
  localparam logic [1:0] OWD_WDT_SEL_288 = 2'h1;
  localparam logic [18:0] OWD_WDT_18MS_US = 19'h04650;
  localparam logic [18:0] OWD_WDT_4P5MS_US = 19'h01194;
  localparam logic [18:0] OWD_WDT_288MS_US = 19'h46500;
  localparam logic [18:0] OWD_WDT_72MS_US = 19'h11940;

  localparam logic [5:0] OWD_GLITCH_SHORT_FC = 6'h08;
  localparam logic [5:0] OWD_GLITCH_LONG_FC = 6'h20;

  localparam logic [1:0] OWD_IRC_SEL_4 = 2'h3;
  localparam logic [1:0] OWD_IRC_SEL_16 = 2'h2;
  localparam logic [1:0] OWD_IRC_SEL_8 = 2'h1;
  localparam logic [4:0] OWD_IRC_4MHZ = 5'h04;
  localparam logic [4:0] OWD_IRC_16MHZ = 5'h10;
  localparam logic [4:0] OWD_IRC_8MHZ = 5'h08;
  localparam logic [4:0] OWD_IRC_1MHZ = 5'h01;

  // ---------------------------------------------------------------
  // avalon register map (word addresses)
  // ---------------------------------------------------------------
  localparam logic [1:0] OWD_ADDR_STATUS = 2'h0;
  localparam logic [1:0] OWD_ADDR_CTRL = 2'h1;
  localparam int OWD_STS_LOADED = 0;
  localparam int OWD_STS_FAULT = 1;
  localparam int OWD_CTRL_FAULT_CLR = 0;

  typedef enum logic {
    OWD_BUS_IDLE = 1'b0,
    OWD_BUS_ACK = 1'b1
  } owd_bus_e;

endpackage

// file: test/owd_tb.sv
// testbench: option word loads through reset, decode and bus checks
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import owd_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, cfg_valid;
  owd_word_t w0, w1, w2;
  logic [1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic ext_reset_pin_en, watchdog_en, instr_four_clocks, lvr_enabled;
  logic [5:0] lvr_trip_dv, lvr_release_dv, int_glitch_width_fc;
  logic [18:0] wdt_timeout_us;
  logic int_falling_edge, int_filter_en, low_power_mode;
  logic [2:0] code_protect;
  logic [4:0] irc_freq_mhz;
  logic [3:0] clock_source_select;
  logic outside_rc_osc_mode, on_chip_rc_osc_mode, crystal_pins_dedicated;
  logic rc_input_is_osc, shared_rc_pin_is_io, clk_out_pin_en;
  logic clk_out_sysclk, clk_out_open_drain, green_sub_128k, pkg_14pin;
  logic [9:0] customer_ident_field;
  logic [76:0] obs, held;
  logic [76:0] exp_dec[$];
  logic [31:0] exp_rd[$];
  logic cv_prev;
  int n_errors, total_checks, seed;
  // 4'h9 is an undefined source code, expected to raise the fault flag
  logic [3:0] codes [0:12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
    4'h6, 4'h7, 4'hf, 4'h9, 4'h3, 4'hf, 4'h6};

  owd_top dut_u (.clk, .rst_n, .otp_word0(w0), .otp_word1(w1),
    .otp_word2(w2), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .cfg_valid, .ext_reset_pin_en,
    .watchdog_en, .instr_four_clocks, .lvr_enabled, .lvr_trip_dv,
    .lvr_release_dv, .wdt_timeout_us, .int_falling_edge,
    .int_glitch_width_fc, .int_filter_en, .code_protect, .low_power_mode,
    .irc_freq_mhz, .clock_source_select, .outside_rc_osc_mode,
    .on_chip_rc_osc_mode, .crystal_pins_dedicated, .rc_input_is_osc,
    .shared_rc_pin_is_io, .clk_out_pin_en, .clk_out_sysclk,
    .clk_out_open_drain, .green_sub_128k, .pkg_14pin,
    .customer_ident_field);

  assign obs = {cfg_valid, ext_reset_pin_en, watchdog_en, instr_four_clocks,
    lvr_enabled, lvr_trip_dv, lvr_release_dv, wdt_timeout_us,
    int_falling_edge, int_glitch_width_fc, int_filter_en, code_protect,
    low_power_mode, irc_freq_mhz, clock_source_select, outside_rc_osc_mode,
    on_chip_rc_osc_mode, crystal_pins_dedicated, rc_input_is_osc,
    shared_rc_pin_is_io, clk_out_pin_en, clk_out_sysclk, clk_out_open_drain,
    green_sub_128k, pkg_14pin, customer_ident_field};

  // ---------------------------------------------------------------
  // expected decode and helpers
  // ---------------------------------------------------------------
  function automatic logic [76:0] dec_exp(input owd_word_t a, b, c);
    logic [3:0] o;
    logic [5:0] tr, rl;
    logic [18:0] wt;
    logic [4:0] fq;
    logic ce, rc;
    o = b[4:1];
    rc = o < 4'h4;
    ce = rc && o[0];
    case (a[9:8])
      2'h3: begin tr = OWD_DV_NONE; rl = OWD_DV_NONE; end
      2'h2: begin tr = OWD_DV_27; rl = OWD_DV_29; end
      2'h1: begin tr = OWD_DV_35; rl = OWD_DV_37; end
      default: begin tr = OWD_DV_40; rl = OWD_DV_40; end
    endcase
    case (a[6:5])
      2'h3: wt = OWD_WDT_18MS_US;
      2'h2: wt = OWD_WDT_4P5MS_US;
      2'h1: wt = OWD_WDT_288MS_US;
      default: wt = OWD_WDT_72MS_US;
    endcase
    case (b[6:5])
      2'h3: fq = OWD_IRC_4MHZ;
      2'h2: fq = OWD_IRC_16MHZ;
      2'h1: fq = OWD_IRC_8MHZ;
      default: fq = OWD_IRC_1MHZ;
    endcase
    return {1'b1, ~a[12], ~a[11], a[10], a[9:8] != 2'h3, tr, rl, wt, 1'b1,
      a[4] ? OWD_GLITCH_LONG_FC : OWD_GLITCH_SHORT_FC, a[3] && o != 4'h6,
      ~a[2:0], ~b[12], fq, o, o < 4'h2, o[3:1] == 3'h1, !rc, o < 4'h2,
      o[3:1] == 3'h1, ce, ce && b[0], ce && !b[0], ~c[11], c[10], c[9:0]};
  endfunction

  task check(input string nm, input logic [76:0] seen, input logic [76:0] e);
    total_checks++;
    if (seen !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask

  // request held until waitrequest is sampled low, then released
  task bus(input logic wr, input logic [1:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= ad;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    check("handshake", n < 50, 1'b1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [1:0] ad, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, ad, 32'h0);
  endtask

  task run_cfg(input int k);
    owd_word_t a, b, c;
    logic [31:0] r;
    logic f;
    int n;
    r = $random(seed);
    a = r[12:0] | 13'h0080;
    r = $random(seed);
    b = {r[12], 5'h1f, r[6:5], codes[k], r[0]};
    r = $random(seed);
    c = r[12:0] | 13'h1000;
    if (k == 10) a[7] = 1'b0;
    if (k == 11) c[12] = 1'b0;
    if (k == 12) b[9] = 1'b0;
    f = !a[7] || !c[12] || b[11:7] != 5'h1f || (b[4:1] > 4'h7 && !(&b[4:1]));
    rst_n <= 1'b0;
    w0 <= a;
    w1 <= b;
    w2 <= c;
    repeat (6) @(posedge clk);
    exp_dec.push_back(dec_exp(a, b, c));
    rst_n <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cfg_valid !== 1'b1 && n < 20);
    check("load", n < 20, 1'b1);
    // later word changes must not reach the decoded outputs
    w0 <= ~a;
    w1 <= ~b;
    w2 <= ~c;
    rd(OWD_ADDR_STATUS, {30'h0, f, 1'b1});
    rd(OWD_ADDR_CTRL, 32'h0);
    rd(2'h2, 32'h0);
    rd(2'h3, 32'h0);
    bus(1'b1, 2'h2, r | 32'h1);
    rd(OWD_ADDR_STATUS, {30'h0, f, 1'b1});
    bus(1'b1, OWD_ADDR_CTRL, r | 32'h1);
    rd(OWD_ADDR_STATUS, 32'h1);
  endtask

  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, monitor, stimulus, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cfg_valid === 1'b1 && cv_prev !== 1'b1) begin
      held = exp_dec.pop_front();
      check("modes", obs[76:33], held[76:33]);
      check("clocks", obs[32:20], held[32:20]);
      check("pins", obs[19:0], held[19:0]);
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      check("readdata", avs_readdata, exp_rd.pop_front());
      check("held", obs, held);
    end
    cv_prev = cfg_valid;
  end

  initial begin
    seed = 26271;
    rst_n = 1'b0;
    w0 = '0;
    w1 = '0;
    w2 = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 2'h0;
    avs_writedata = 32'h0;
    cv_prev = 1'b0;
    @(posedge clk);
    for (int k = 0; k < 13; k++) run_cfg(k);
    check("queues", exp_rd.size() == 0 && exp_dec.size() == 0, 1'b1);
    tally_and_finish();
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    $display("mismatch watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule
`default_nettype wire
